// [temp_readout_pkg.sv]
// constants, register map and state type of the temperature readout block
// assumes one byte-wide register port from the management bus slave
`default_nettype none
package temp_readout_pkg;
    localparam int NUM_CH = 7;
    localparam int NUM_ANALOG = 3;
    // channel order: remote one, local, remote two, cpu zero to three
    localparam logic [NUM_CH-1:0][7:0] OFFSET_ADDR =
        {8'h97, 8'h96, 8'h95, 8'h94, 8'h72, 8'h71, 8'h70};
    localparam logic [NUM_CH-1:0][7:0] VALUE_ADDR =
        {8'hA3, 8'hA2, 8'hA1, 8'h33, 8'h27, 8'h26, 8'h25};
    localparam logic [NUM_CH-1:0][7:0] LOW_ADDR =
        {8'hA8, 8'hA6, 8'hA4, 8'h34, 8'h52, 8'h50, 8'h4E};
    localparam logic [NUM_CH-1:0][7:0] HIGH_ADDR =
        {8'hA9, 8'hA7, 8'hA5, 8'h35, 8'h53, 8'h51, 8'h4F};
    localparam logic [7:0] EXT_RES_ADDR = 8'h77;
    localparam logic [7:0] CONFIG_ADDR = 8'h7C;
    localparam logic [7:0] STATUS_ADDR = 8'hB0;
    localparam logic [7:0] MASK_ADDR = 8'hB1;
    localparam logic [7:0] PIN_CFG_ADDR = 8'hB2;
    localparam int OFFSET_SCALE_BIT = 1;
    localparam int ALERT_EN_BIT = 0;
    localparam int EXT_FIELD_W = 2;
    localparam logic [NUM_CH-1:0][7:0] LOW_RST =
        {8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81};
    localparam logic [NUM_CH-1:0][7:0] HIGH_RST =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'h7F};
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [9:0] SAT_POS = 10'h1FF;
    localparam logic [9:0] SAT_NEG = 10'h200;

    typedef struct packed {
        logic [NUM_CH-1:0][7:0] offset;
        logic [NUM_CH-1:0][7:0] high_lim;
        logic [NUM_CH-1:0][7:0] low_lim;
        logic [NUM_CH-1:0][9:0] result;
        logic [NUM_CH-1:0][9:0] pending;
        logic [NUM_CH-1:0] pend_valid;
        logic [NUM_CH-1:0] status;
        logic [NUM_CH-1:0] mask;
        logic [NUM_CH-1:0] seen;
        logic [7:0] config_reg;
        logic alert_en;
        logic freeze;
        logic [7:0] rdata;
        logic alert_drive;
    } readout_state_t;

    localparam readout_state_t STATE_RST = '{
        offset: '0, high_lim: HIGH_RST, low_lim: LOW_RST,
        result: '0, pending: '0, pend_valid: '0, status: '0,
        mask: '0, seen: '0, config_reg: CONFIG_RST, alert_en: 1'b0,
        freeze: 1'b0, rdata: 8'h00, alert_drive: 1'b0};
endpackage
`default_nettype wire

// [calc_if.sv]
// carries one measurement through offset correction and limit check
// assumes the core drives inputs and reads back sum and flag in one cycle
`default_nettype none
interface calc_if;
    logic [9:0] meas;
    logic [7:0] offset;
    logic half_step;
    logic [9:0] sum;
    logic [7:0] high_lim;
    logic [7:0] low_lim;
    logic beyond;
    modport core (output meas, offset, half_step, high_lim, low_lim,
                  input sum, beyond);
    modport adder (input meas, offset, half_step, output sum);
    modport cmp (input sum, high_lim, low_lim, output beyond);
endinterface
`default_nettype wire

// [offset_adder.sv]
// signed offset correction of a quarter-degree reading, saturating
// assumes meas and offset are two's complement
`default_nettype none
module offset_adder (
    calc_if.adder c
);
    import temp_readout_pkg::*;
    logic [11:0] scaled;
    logic [11:0] wide;

    always_comb begin
        // half-degree step doubles, whole-degree step quadruples
        // half-degree offset span
        if (c.half_step) begin
            scaled = {{3{c.offset[7]}}, c.offset, 1'b0};
        end else begin
            scaled = {{2{c.offset[7]}}, c.offset, 2'b00};
        end
        wide = scaled + {{2{c.meas[9]}}, c.meas};
        if (wide[11:9] == 3'h0 || wide[11:9] == 3'h7) begin
            c.sum = wide[9:0];
        end else if (wide[11]) begin
            c.sum = SAT_NEG;
        end else begin
            c.sum = SAT_POS;
        end
    end
endmodule
`default_nettype wire

// [limit_cmp.sv]
// window comparison of the whole-degree part against two limits
// assumes signed 8-bit limits
`default_nettype none
module limit_cmp (
    calc_if.cmp c
);
    logic signed [7:0] whole;

    assign whole = c.sum[9:2];
    // above high, at or below low
    assign c.beyond = (whole > $signed(c.high_lim)) ||
                      (whole <= $signed(c.low_lim));
endmodule
`default_nettype wire

// [temp_result_offset_readout.sv]
// temperature result post-processing, limit check and readout registers
// assumes a bus slave turning host cycles into one-cycle read/write strobes
`default_nettype none
module temp_result_offset_readout (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var logic [7:0] reg_rdata,
    // measurements
    input wire logic meas_valid,
    input wire logic [2:0] meas_chan,
    input wire logic [9:0] meas_value,
    // alert pin, pulled low while high
    output var logic alert_drive
);
    import temp_readout_pkg::*;

    readout_state_t st_q;
    readout_state_t st_d;
    logic [7:0] rd_word;
    logic [7:0] ext_word;
    logic chan_ok;
    logic [2:0] idx;
    logic ext_read;
    logic half_ref;
    logic [11:0] ref_wide;
    logic [9:0] ref_sum;

    calc_if calc ();

    offset_adder u_adder (
        .c(calc)
    );

    limit_cmp u_cmp (
        .c(calc)
    );

    assign chan_ok = (meas_chan < 3'(NUM_CH));
    assign idx = chan_ok ? meas_chan : 3'h0;
    assign ext_read = reg_rd && (reg_addr == EXT_RES_ADDR);

    assign calc.meas = meas_value;
    assign calc.offset = st_q.offset[idx];
    assign calc.half_step = (idx < 3'(NUM_ANALOG)) &&
                            !st_q.config_reg[OFFSET_SCALE_BIT];
    assign calc.high_lim = st_q.high_lim[idx];
    assign calc.low_lim = st_q.low_lim[idx];

    always_comb begin
        st_d = st_q;
        rd_word = 8'h00;
        ext_word = 8'h00;
        // low bits packed per analog channel
        for (int i = 0; i < NUM_ANALOG; i++) begin
            ext_word[EXT_FIELD_W*i +: EXT_FIELD_W] = st_q.result[i][1:0];
        end
        // read mux
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == VALUE_ADDR[i]) begin
                rd_word = st_q.result[i][9:2];
            end
            if (reg_addr == OFFSET_ADDR[i]) begin
                rd_word = st_q.offset[i];
            end
            if (reg_addr == HIGH_ADDR[i]) begin
                rd_word = st_q.high_lim[i];
            end
            if (reg_addr == LOW_ADDR[i]) begin
                rd_word = st_q.low_lim[i];
            end
        end
        if (reg_addr == EXT_RES_ADDR) begin
            rd_word = ext_word;
        end
        if (reg_addr == CONFIG_ADDR) begin
            rd_word = st_q.config_reg;
        end
        if (reg_addr == STATUS_ADDR) begin
            rd_word = {1'b0, st_q.status};
        end
        if (reg_addr == MASK_ADDR) begin
            rd_word = {1'b0, st_q.mask};
        end
        if (reg_addr == PIN_CFG_ADDR) begin
            rd_word = {7'h00, st_q.alert_en};
        end
        if (reg_rd) begin
            st_d.rdata = rd_word;
        end
        // register writes
        if (reg_wr) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr == OFFSET_ADDR[i]) begin
                    st_d.offset[i] = reg_wdata;
                end
                if (reg_addr == HIGH_ADDR[i]) begin
                    st_d.high_lim[i] = reg_wdata;
                end
                if (reg_addr == LOW_ADDR[i]) begin
                    st_d.low_lim[i] = reg_wdata;
                end
            end
            if (reg_addr == CONFIG_ADDR) begin
                st_d.config_reg = reg_wdata;
            end
            if (reg_addr == MASK_ADDR) begin
                st_d.mask = reg_wdata[NUM_CH-1:0];
            end
            if (reg_addr == PIN_CFG_ADDR) begin
                st_d.alert_en = reg_wdata[ALERT_EN_BIT];
            end
        end
        if (ext_read) begin
            st_d.freeze = 1'b1;
            st_d.seen = '0;
        end else if (reg_rd && st_q.freeze) begin
            // reads tick off values; the read completing the set releases and applies held results
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr == VALUE_ADDR[i]) begin
                    st_d.seen[i] = 1'b1;
                end
            end
            if (&st_d.seen) begin
                st_d.freeze = 1'b0;
                for (int i = 0; i < NUM_CH; i++) begin
                    if (st_q.pend_valid[i]) begin
                        st_d.result[i] = st_q.pending[i];
                    end
                end
                st_d.pend_valid = '0;
            end
        end
        if (meas_valid && chan_ok) begin
            st_d.status[idx] = calc.beyond;
            if (st_d.freeze) begin
                st_d.pending[idx] = calc.sum;
                st_d.pend_valid[idx] = 1'b1;
            end else begin
                st_d.result[idx] = calc.sum;
            end
        end
        st_d.alert_drive = st_d.alert_en && |(st_d.status & ~st_d.mask);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign alert_drive = st_q.alert_drive;

    // reference correction for checking
    assign half_ref = (meas_chan < 3'(NUM_ANALOG)) &&
                      !st_q.config_reg[OFFSET_SCALE_BIT];
    assign ref_wide = $signed({{2{meas_value[9]}}, meas_value}) +
                      $signed({{4{calc.offset[7]}}, calc.offset}) *
                      (half_ref ? 12'sd2 : 12'sd4);
    assign ref_sum = ($signed(ref_wide) > 12'sd511) ? SAT_POS :
                     ($signed(ref_wide) < -12'sd512) ? SAT_NEG :
                     ref_wide[9:0];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ext_read;
        reg_rd && (reg_addr == EXT_RES_ADDR);
    endsequence

    sequence s_release;
        st_q.freeze && !st_d.freeze && !meas_valid;
    endsequence

    property p_ext_read_freezes;
        s_ext_read |=> st_q.freeze && (st_q.seen == '0);
    endproperty
    a_ext_read_freezes: assert property (p_ext_read_freezes)
        else $error("extended read did not freeze results");

    property p_frozen_hold;
        st_q.freeze ##1 st_q.freeze |-> $stable(st_q.result);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold)
        else $error("result changed while frozen");

    property p_plain_read;
        !st_q.freeze && reg_rd && (reg_addr != EXT_RES_ADDR)
            |=> !st_q.freeze;
    endproperty
    a_plain_read: assert property (p_plain_read)
        else $error("plain read started a freeze");

    property p_value_read;
        reg_rd && (reg_addr == VALUE_ADDR[0])
            |=> reg_rdata == $past(st_q.result[0][9:2]);
    endproperty
    a_value_read: assert property (p_value_read)
        else $error("value byte read wrong");

    property p_ext_bits;
        s_ext_read |=> reg_rdata[1:0] == $past(st_q.result[0][1:0]);
    endproperty
    a_ext_bits: assert property (p_ext_bits)
        else $error("extended bits read wrong");

    property p_half_step;
        meas_valid && (meas_chan < 3'(NUM_ANALOG)) && !st_d.freeze &&
            !st_q.config_reg[OFFSET_SCALE_BIT]
            |=> st_q.result[$past(idx)] == $past(ref_sum);
    endproperty
    a_half_step: assert property (p_half_step)
        else $error("half-degree offset not applied");

    property p_full_step;
        meas_valid && (meas_chan < 3'(NUM_ANALOG)) && !st_d.freeze &&
            st_q.config_reg[OFFSET_SCALE_BIT]
            |=> st_q.result[$past(idx)] == $past(ref_sum);
    endproperty
    a_full_step: assert property (p_full_step)
        else $error("whole-degree offset not applied");

    property p_cpu_step;
        meas_valid && chan_ok && (meas_chan >= 3'(NUM_ANALOG)) &&
            !st_d.freeze |=> st_q.result[$past(idx)] == $past(ref_sum);
    endproperty
    a_cpu_step: assert property (p_cpu_step)
        else $error("cpu offset not whole-degree");

    property p_limit_status;
        meas_valid && chan_ok |=> st_q.status[$past(idx)] ==
            ($past($signed(ref_sum[9:2]) > $signed(calc.high_lim)) ||
             $past($signed(ref_sum[9:2]) <= $signed(calc.low_lim)));
    endproperty
    a_limit_status: assert property (p_limit_status)
        else $error("status does not match limit compare");

    property p_alert_gate;
        alert_drive == (st_q.alert_en && |(st_q.status & ~st_q.mask));
    endproperty
    a_alert_gate: assert property (p_alert_gate)
        else $error("alert not gated by mask and pin config");

    property p_release;
        s_release |=> !st_q.freeze && (st_q.pend_valid == '0) &&
            (st_q.result[0] == $past(st_q.pend_valid[0] ?
             st_q.pending[0] : st_q.result[0]));
    endproperty
    a_release: assert property (p_release)
        else $error("held result not applied on release");

    property p_hold_aside;
        meas_valid && chan_ok && st_q.freeze && st_d.freeze
            |=> st_q.pend_valid[$past(idx)] && $stable(st_q.result);
    endproperty
    a_hold_aside: assert property (p_hold_aside)
        else $error("new result not held aside while frozen");

    property p_offset_readback;
        reg_wr && (reg_addr == OFFSET_ADDR[1]) ##1 !reg_wr ##1
            reg_rd && (reg_addr == OFFSET_ADDR[1]) && !reg_wr
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_offset_readback: assert property (p_offset_readback)
        else $error("offset register readback wrong");

    property p_unmapped_read;
        reg_rd && (reg_addr == 8'hFF) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address did not read zero");

    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a read");

    property p_status_read;
        reg_rd && (reg_addr == STATUS_ADDR)
            |=> reg_rdata == {1'b0, $past(st_q.status)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status register read wrong");

    property p_status_frozen;
        meas_valid && chan_ok && st_q.freeze
            |=> st_q.status[$past(idx)] == $past(calc.beyond);
    endproperty
    a_status_frozen: assert property (p_status_frozen)
        else $error("status not updated while frozen");

    property p_ext_layout;
        s_ext_read |=> (reg_rdata[3:2] == $past(st_q.result[1][1:0])) &&
            (reg_rdata[5:4] == $past(st_q.result[2][1:0])) &&
            (reg_rdata[7:6] == 2'b00);
    endproperty
    a_ext_layout: assert property (p_ext_layout)
        else $error("extended bits layout wrong");

    property p_config_write;
        reg_wr && (reg_addr == CONFIG_ADDR)
            |=> st_q.config_reg == $past(reg_wdata);
    endproperty
    a_config_write: assert property (p_config_write)
        else $error("offset scaling config not stored");
endmodule
`default_nettype wire

// [temp_result_offset_readout_unused_guard.sv]
// holds no logic, only the implicit-net bracket
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

// [host_model.sv]
// host-side model of the register port: strobed reads and writes
// assumes ref_clk from the bench; drives only just after falling edges
`default_nettype none
module host_model
    import temp_readout_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register port
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic reg_wr,
    output var logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // released lines show the inverse, never the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        q = reg_rdata;
    endtask

    // extended bits read before the byte
    task automatic rd10(input int ch, output logic [9:0] q);
        logic [7:0] e;
        logic [7:0] h;
        rd(EXT_RES_ADDR, e);
        rd(VALUE_ADDR[ch], h);
        q = {h, e[2*ch +: 2]};
    endtask

    // two corrections as one summed offset
    task automatic set_off(input int ch, input logic [7:0] a,
                           input logic [7:0] b);
        wr(OFFSET_ADDR[ch], a + b);
    endtask
endmodule
`default_nettype wire

// [temp_result_offset_readout_test.sv]
// self-checking bench for the temperature readout block
// assumes the host model drives the register port
`default_nettype none
module temp_result_offset_readout_test
    import temp_readout_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic resetn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic meas_valid;
    logic [2:0] meas_chan;
    logic [9:0] meas_value;
    logic alert_drive;
    logic [7:0] q;
    logic [9:0] q10;
    logic [9:0] e;
    int bad_count = 0;
    int n_checks = 0;
    int c_ch [5] = '{0, 0, 1, 3, 2};
    logic [7:0] c_off [5] = '{8'h04, 8'h04, 8'hFE, 8'h04, 8'h7F};
    logic [7:0] c_cfg [5] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h02};
    logic [9:0] c_v [5] = '{10'h064, 10'h064, 10'h065, 10'h064, 10'h1F0};

    host_model host (
        .ref_clk(ref_clk),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    temp_result_offset_readout uut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .meas_valid(meas_valid),
        .meas_chan(meas_chan),
        .meas_value(meas_value),
        .alert_drive(alert_drive)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [9:0] seen,
                       input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic meas(input int ch, input logic [9:0] v);
        @(negedge ref_clk);
        meas_chan = 3'(ch);
        meas_value = v;
        meas_valid = 1'b1;
        @(negedge ref_clk);
        meas_valid = 1'b0;
        meas_value = ~v;
    endtask

    // expected stored value: offset times two or four quarter steps, saturating
    function automatic logic [9:0] adj(input logic [9:0] v,
                                       input logic [7:0] o, input int k);
        int s;
        s = int'($signed(v)) + int'($signed(o)) * k;
        if (s > 511) s = 511;
        if (s < -512) s = -512;
        return s[9:0];
    endfunction

    // measure on channel zero, then status bit and alert pin
    task automatic lim(input logic [7:0] deg, input logic st,
                       input logic al);
        meas(0, {deg, 2'b00});
        chk("alert", 10'(alert_drive), 10'(al));
        host.rd(STATUS_ADDR, q);
        chk("status", 10'(q[0]), 10'(st));
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        meas_valid = 1'b0;
        meas_chan = 3'h0;
        meas_value = 10'h000;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            host.rd(OFFSET_ADDR[i], q);
            chk("offset reset", 10'(q), 10'h000);
        end
        host.rd(CONFIG_ADDR, q);
        chk("config reset", 10'(q), 10'(CONFIG_RST));
        host.rd(8'hFF, q);
        chk("unmapped", 10'(q), 10'h000);
        for (int i = 0; i < 3; i++) begin
            host.wr(OFFSET_ADDR[i], 8'(8'h11 + i));
            host.rd(OFFSET_ADDR[i], q);
            chk("offset rw", 10'(q), 10'(8'h11 + i));
        end
        for (int i = 0; i < 5; i++) begin
            host.wr(CONFIG_ADDR, c_cfg[i]);
            host.set_off(c_ch[i], c_off[i], 8'h00);
            meas(c_ch[i], c_v[i]);
            e = adj(c_v[i], c_off[i],
                    (c_ch[i] >= 3 || c_cfg[i][1]) ? 4 : 2);
            host.rd(VALUE_ADDR[c_ch[i]], q);
            chk("value byte", 10'(q), 10'(e[9:2]));
            host.rd(VALUE_ADDR[c_ch[i]], q);
            chk("value again", 10'(q), 10'(e[9:2]));
        end
        host.wr(CONFIG_ADDR, 8'h00);
        host.set_off(0, 8'h03, 8'hFD);
        host.wr(HIGH_ADDR[0], 8'h1E);
        host.wr(LOW_ADDR[0], 8'h0A);
        // mask all but channel zero: cpu zero sits above its zero high limit
        host.wr(MASK_ADDR, 8'h7E);
        host.wr(PIN_CFG_ADDR, 8'h01);
        lim(8'd31, 1'b1, 1'b1);
        lim(8'd30, 1'b0, 1'b0);
        lim(8'd10, 1'b1, 1'b1);
        lim(8'd11, 1'b0, 1'b0);
        host.wr(MASK_ADDR, 8'h7F);
        lim(8'd31, 1'b1, 1'b0);
        host.wr(MASK_ADDR, 8'h7E);
        host.wr(PIN_CFG_ADDR, 8'h00);
        lim(8'd31, 1'b1, 1'b0);
        meas(0, 10'h0A5);
        host.rd10(0, q10);
        chk("ten bit", q10, 10'h0A5);
        meas(0, 10'h0C2);
        host.rd(VALUE_ADDR[0], q);
        chk("frozen", 10'(q), 10'h029);
        for (int i = 1; i < NUM_CH; i++) begin
            host.rd(VALUE_ADDR[i], q);
        end
        host.rd(VALUE_ADDR[0], q);
        chk("released", 10'(q), 10'h030);
        end_of_test();
    end
endmodule
`default_nettype wire
